//--- logic/panel_pkg.sv
package panel_pkg;

  localparam int CLK_HZ        = 250_000_000;
  localparam int DEBOUNCE_MS   = 20;
  localparam int BLINK_HALF_MS = 250;
  localparam int STEP_MS       = 200;
  localparam int BAUD_RATE     = 19_200;

  localparam int DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam int STEP_CYC       = (CLK_HZ / 1000) * STEP_MS;
  localparam int BAUD_CYC       = CLK_HZ / BAUD_RATE;

  localparam int CNT_W  = 27;
  localparam int BAUD_W = 16;
  localparam int DLY_W  = 5;
  localparam int IRQ_W  = 4;

  // 4 s of relay delay in 200 ms steps
  localparam logic [DLY_W-1:0] DLY_MAX = 5'h14;

  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_INCFG     = 8'h04;
  localparam logic [7:0] ADR_DELAY     = 8'h08;
  localparam logic [7:0] ADR_STATUS    = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h14;
  localparam logic [7:0] ADR_LATCH_RST = 8'h18;

  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_ALARM1  = 1;
  localparam int IRQ_ALARM2  = 2;
  localparam int IRQ_BREAK   = 3;

  localparam logic [1:0] UNIT_C    = 2'h0;
  localparam logic [1:0] UNIT_F    = 2'h1;
  localparam logic [1:0] UNIT_K    = 2'h2;
  localparam logic [2:0] FUNC_LIM  = 3'h0;
  localparam logic [2:0] FUNC_ROC  = 3'h5;
  localparam logic [1:0] WIRE_2    = 2'h0;
  localparam logic [1:0] WIRE_4    = 2'h2;

  typedef enum logic [2:0] {M_NORMAL, M_R1P1, M_R1P2, M_R2P1, M_R2P2} mode_t;

  typedef struct packed {
    logic [1:0] wiring;
    logic [2:0] func;
    logic       brk_up;
    logic [1:0] unit;
  } in_cfg_t;

  typedef struct packed {
    logic       mode;
    logic       set;
    logic [1:0] reset;
  } buttons_t;

  typedef struct packed {
    logic       run;
    logic       status;
    logic [1:0] alarm;
  } lamps_t;

  typedef struct packed {
    logic [28:0] pad;
    logic [1:0]  latch_en;
    logic        cfg_ok;
  } ctrl_t;

  typedef struct packed {
    logic [18:0] pad;
    logic        diag_fail;
    logic        diag_busy;
    logic [1:0]  sensor_break;
    logic [1:0]  reset_pend;
    logic [1:0]  latched;
    logic [1:0]  relay;
    mode_t       mode;
  } status_t;

endpackage : panel_pkg

//--- logic/alarm_front_panel_control.sv
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
// Functional notes
// (RULE1) normal mode, no fault: run lamp steady on
// (RULE2) run lamp flashes during power-up diagnostics and after they fail
// (RULE3) status lamp flashes while any sensor is open or broken
// (RULE4) outside configuration, each alarm lamp is steady on while its relay alarms
// (RULE5) configuration mode turns the run lamp off
// (RULE6) configuration mode: status lamp blinks once per captured set press
// (RULE7) configuration: alarm lamp steady for parameter 1, flashing for parameter 2
// (RULE8) mode button steps through the configuration modes
// (RULE9) set button in configuration captures present input as the parameter
// (RULE10) reset button 1 or 2 clears the latched alarm of its relay
// (RULE11) no field configuration until the host has loaded a configuration
// (RULE12) host serial link runs at fixed 19.2K baud
// (RULE13) each input holds a unit selection: Celsius, Fahrenheit or kelvin
// (RULE14) each input holds an upscale or downscale sensor-break direction
// (RULE15) each input holds one of six alarm functions
// (RULE16) each input holds two-, three- or four-wire sensor wiring
// (RULE17) latch reset acts only when input normal and relay delay expired
// (RULE18) relay delay 0 to 4 s in 200 ms steps, on entry and exit
// (RULE19) all flashing from one 2 Hz 50 % blink; buttons debounced 20 ms
module alarm_front_panel_control #(
  parameter int DEBOUNCE_CYCLES   = panel_pkg::DEBOUNCE_CYC,
  parameter int BLINK_HALF_CYCLES = panel_pkg::BLINK_HALF_CYC,
  parameter int STEP_CYCLES       = panel_pkg::STEP_CYC,
  parameter int BAUD_CYCLES       = panel_pkg::BAUD_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire panel_pkg::buttons_t  buttons_i,
  input  wire logic [1:0]           alarm_i,
  input  wire logic [1:0]           sensor_break_i,
  input  wire logic                 diag_busy_i,
  input  wire logic                 diag_fail_i,
  output panel_pkg::lamps_t         lamps_o,
  output logic [1:0]                relay_o,
  output logic [1:0]                latch_clear_o,
  output logic                      capture_o,
  output logic [1:0]                capture_sel_o,
  output panel_pkg::in_cfg_t [1:0]  in_cfg_o,
  output logic                      baud_tick_o,
  output logic                      irq_o
);

  localparam int CW = panel_pkg::CNT_W;

  typedef struct packed {
    panel_pkg::mode_t                   mode;
    logic [3:0]                         db;
    logic [3:0][CW-1:0]                 db_cnt;
    logic [CW-1:0]                      blink_cnt;
    logic                               blink;
    logic [CW-1:0]                      step_cnt;
    logic                               tick;
    logic [panel_pkg::BAUD_W-1:0]       baud_cnt;
    logic                               baud_tick;
    logic [1:0]                         relay;
    logic [1:0][panel_pkg::DLY_W-1:0]   dly_cnt;
    logic [1:0]                         latched;
    logic [1:0]                         rst_req;
    logic [1:0]                         clr;
    logic [CW-1:0]                      sblink_cnt;
    logic                               capture;
    logic [1:0]                         cap_sel;
    logic                               cfg_ok;
    logic [1:0]                         latch_en;
    panel_pkg::in_cfg_t [1:0]           in_cfg;
    logic [panel_pkg::DLY_W-1:0]        delay;
    logic [panel_pkg::IRQ_W-1:0]        irq_stat;
    logic [panel_pkg::IRQ_W-1:0]        irq_mask;
    logic                               brk_q;
    logic                               irq;
    logic                               ack;
    logic [31:0]                        rdat;
    panel_pkg::lamps_t                  lamps;
    logic [1:0]                         relay_out;
  } state_t;

  state_t s;
  state_t next_s;

  logic [3:0]                  press;
  logic [1:0]                  rise;
  logic [1:0]                  sw_rst;
  logic [panel_pkg::IRQ_W-1:0] w1c;
  logic [panel_pkg::IRQ_W-1:0] ev;
  logic                        req;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic logic cfg_legal(input panel_pkg::in_cfg_t c);
    return (c.unit <= panel_pkg::UNIT_K) && (c.func <= panel_pkg::FUNC_ROC)
        && (c.wiring <= panel_pkg::WIRE_4);
  endfunction : cfg_legal

  always_comb begin
    logic [31:0] m;
    panel_pkg::ctrl_t   cw;
    panel_pkg::status_t st;
    panel_pkg::in_cfg_t [1:0] ic;
    m      = '0;
    cw     = '0;
    st     = '0;
    ic     = '0;
    next_s = s;
    press  = '0;
    rise   = '0;
    sw_rst = '0;
    w1c    = '0;

    // register bus: one wait state, ack drops after one cycle
    req          = wb_cyc_i & wb_stb_i & ~s.ack;
    next_s.ack   = req;
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        panel_pkg::ADR_CTRL: begin
          cw = panel_pkg::ctrl_t'(wmerge(32'(panel_pkg::ctrl_t'({29'h0, s.latch_en, s.cfg_ok})),
                                         wb_dat_i, wb_sel_i));
          next_s.cfg_ok   = cw.cfg_ok;
          next_s.latch_en = cw.latch_en;
        end
        panel_pkg::ADR_INCFG: begin
          m  = wmerge({16'h0000, s.in_cfg}, wb_dat_i, wb_sel_i);
          ic = m[15:0];
          for (int i = 0; i < 2; i++) begin
            // illegal encodings leave the field unchanged
            if (cfg_legal(ic[i])) begin // [RULE13] [RULE14] [RULE15] [RULE16]
              next_s.in_cfg[i] = ic[i];
            end
          end
        end
        panel_pkg::ADR_DELAY: begin
          m = wmerge({27'h0, s.delay}, wb_dat_i, wb_sel_i);
          next_s.delay = (m[panel_pkg::DLY_W-1:0] > panel_pkg::DLY_MAX) ? // [RULE18]
                         panel_pkg::DLY_MAX : m[panel_pkg::DLY_W-1:0];
        end
        panel_pkg::ADR_IRQ_STAT: begin
          m   = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
          w1c = m[panel_pkg::IRQ_W-1:0];
        end
        panel_pkg::ADR_IRQ_MASK: begin
          m = wmerge({28'h0, s.irq_mask}, wb_dat_i, wb_sel_i);
          next_s.irq_mask = m[panel_pkg::IRQ_W-1:0];
        end
        panel_pkg::ADR_LATCH_RST: begin
          m      = wmerge(32'h0000_0000, wb_dat_i, wb_sel_i);
          sw_rst = m[1:0];
        end
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      st.diag_fail    = diag_fail_i;
      st.diag_busy    = diag_busy_i;
      st.sensor_break = sensor_break_i;
      st.reset_pend   = s.rst_req;
      st.latched      = s.latched;
      st.relay        = s.relay;
      st.mode         = s.mode;
      unique case (wb_adr_i)
        panel_pkg::ADR_CTRL:     next_s.rdat = {29'h0, s.latch_en, s.cfg_ok};
        panel_pkg::ADR_INCFG:    next_s.rdat = {16'h0000, s.in_cfg};
        panel_pkg::ADR_DELAY:    next_s.rdat = {27'h0, s.delay};
        panel_pkg::ADR_STATUS:   next_s.rdat = st;
        panel_pkg::ADR_IRQ_STAT: next_s.rdat = {28'h0, s.irq_stat};
        panel_pkg::ADR_IRQ_MASK: next_s.rdat = {28'h0, s.irq_mask};
        default:                 next_s.rdat = 32'h0000_0000;
      endcase
    end

    // one shared time base keeps every flashing lamp in phase
    for (int i = 0; i < 4; i++) begin
      if (buttons_i[i] == s.db[i]) begin
        next_s.db_cnt[i] = '0;
      end else if (s.db_cnt[i] == CW'(DEBOUNCE_CYCLES - 1)) begin // [RULE19]
        next_s.db[i]     = buttons_i[i];
        next_s.db_cnt[i] = '0;
        press[i]         = buttons_i[i];
      end else begin
        next_s.db_cnt[i] = s.db_cnt[i] + 1'b1;
      end
    end
    if (s.blink_cnt == CW'(BLINK_HALF_CYCLES - 1)) begin // [RULE19]
      next_s.blink_cnt = '0;
      next_s.blink     = ~s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 1'b1;
    end
    next_s.tick = (s.step_cnt == CW'(STEP_CYCLES - 1));
    next_s.step_cnt = next_s.tick ? '0 : s.step_cnt + 1'b1;
    next_s.baud_tick = (s.baud_cnt == panel_pkg::BAUD_W'(BAUD_CYCLES - 1)); // [RULE12]
    next_s.baud_cnt  = next_s.baud_tick ? '0 : s.baud_cnt + 1'b1;

    // delay counts whole steps; the first step may be short by up to one step
    for (int i = 0; i < 2; i++) begin
      if (alarm_i[i] == s.relay[i]) begin
        next_s.dly_cnt[i] = '0;
      end else if (s.dly_cnt[i] >= s.delay) begin // [RULE18]
        next_s.relay[i]   = alarm_i[i];
        next_s.dly_cnt[i] = '0;
      end else if (s.tick) begin
        next_s.dly_cnt[i] = s.dly_cnt[i] + 1'b1;
      end
      rise[i] = next_s.relay[i] & ~s.relay[i];
      next_s.clr[i] = 1'b0;
      // relay low means input is back in range and the delay has run out
      if (s.rst_req[i] && !s.relay[i]) begin // [RULE17]
        next_s.latched[i] = 1'b0;
        next_s.clr[i]     = s.latched[i];
        next_s.rst_req[i] = 1'b0;
      end
      if (press[i] || sw_rst[i]) begin // [RULE10]
        next_s.rst_req[i] = 1'b1;
      end
      if (rise[i] && s.latch_en[i]) begin
        next_s.latched[i] = 1'b1;
      end
    end

    if (press[3]) begin // [RULE8]
      unique case (s.mode)
        panel_pkg::M_NORMAL: next_s.mode = s.cfg_ok ? panel_pkg::M_R1P1 : // [RULE11]
                                           panel_pkg::M_NORMAL;
        panel_pkg::M_R1P1:   next_s.mode = panel_pkg::M_R1P2;
        panel_pkg::M_R1P2:   next_s.mode = panel_pkg::M_R2P1;
        panel_pkg::M_R2P1:   next_s.mode = panel_pkg::M_R2P2;
        panel_pkg::M_R2P2:   next_s.mode = panel_pkg::M_NORMAL;
      endcase
    end

    next_s.capture = 1'b0;
    if (press[2] && s.mode != panel_pkg::M_NORMAL) begin // [RULE9]
      next_s.capture    = 1'b1;
      next_s.cap_sel    = 2'(s.mode - panel_pkg::M_R1P1);
      next_s.sblink_cnt = CW'(BLINK_HALF_CYCLES); // [RULE6]
    end else if (s.sblink_cnt != '0) begin
      next_s.sblink_cnt = s.sblink_cnt - 1'b1;
    end

    ev                       = '0;
    ev[panel_pkg::IRQ_CAPTURE] = next_s.capture;
    ev[panel_pkg::IRQ_ALARM1]  = rise[0];
    ev[panel_pkg::IRQ_ALARM2]  = rise[1];
    ev[panel_pkg::IRQ_BREAK]   = (|sensor_break_i) & ~s.brk_q;
    next_s.brk_q    = |sensor_break_i;
    // a new event beats a clear in the same cycle
    next_s.irq_stat = (s.irq_stat & ~w1c) | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);

    next_s.relay_out = s.relay | s.latched;
    if (s.mode == panel_pkg::M_NORMAL) begin
      next_s.lamps.run    = (diag_busy_i | diag_fail_i) ? s.blink : 1'b1; // [RULE1] [RULE2]
      next_s.lamps.status = (|sensor_break_i) & s.blink; // [RULE3]
      next_s.lamps.alarm  = s.relay | s.latched; // [RULE4]
    end else begin
      next_s.lamps.run      = 1'b0; // [RULE5]
      next_s.lamps.status   = (s.sblink_cnt != '0); // [RULE6]
      next_s.lamps.alarm[0] = (s.mode == panel_pkg::M_R1P1) | // [RULE7]
                              ((s.mode == panel_pkg::M_R1P2) & s.blink);
      next_s.lamps.alarm[1] = (s.mode == panel_pkg::M_R2P1) |
                              ((s.mode == panel_pkg::M_R2P2) & s.blink);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o      = s.rdat;
  assign wb_ack_o      = s.ack;
  assign lamps_o       = s.lamps;
  assign relay_o       = s.relay_out;
  assign latch_clear_o = s.clr;
  assign capture_o     = s.capture;
  assign capture_sel_o = s.cap_sel;
  assign in_cfg_o      = s.in_cfg;
  assign baud_tick_o   = s.baud_tick;
  assign irq_o         = s.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // the releasing edge itself still resets the lamps, so it is left out
  a_run_steady_on: assert property ( // [RULE1]
    (!rst_i && s.mode == panel_pkg::M_NORMAL && !diag_busy_i && !diag_fail_i) |=> lamps_o.run)
    else $error("run lamp not steady in normal operation");
  a_run_diag_flash: assert property ( // [RULE2]
    (s.mode == panel_pkg::M_NORMAL && diag_fail_i) |=> lamps_o.run == $past(s.blink))
    else $error("run lamp not following blink on diagnostic fault");
  a_status_break: assert property ( // [RULE3]
    (s.mode == panel_pkg::M_NORMAL) |=> lamps_o.status == $past(|sensor_break_i & s.blink))
    else $error("status lamp wrong for sensor break");
  a_alarm_lamp_follow: assert property ( // [RULE4]
    (s.mode == panel_pkg::M_NORMAL) |=> lamps_o.alarm == $past(s.relay | s.latched))
    else $error("alarm lamp not following relay");
  a_run_off_config: assert property ( // [RULE5]
    (s.mode != panel_pkg::M_NORMAL) |=> !lamps_o.run)
    else $error("run lamp lit in configuration");
  a_set_blink_once: assert property ( // [RULE6]
    (press[2] && s.mode != panel_pkg::M_NORMAL && !press[3]) |=> capture_o ##1 lamps_o.status)
    else $error("set press did not capture and blink");
  a_param_one_lamp: assert property ( // [RULE7]
    (s.mode == panel_pkg::M_R1P1) |=> lamps_o.alarm[0])
    else $error("relay 1 lamp not steady for parameter 1");
  a_mode_step: assert property ( // [RULE8]
    (press[3] && s.mode == panel_pkg::M_R1P1) |=> s.mode == panel_pkg::M_R1P2)
    else $error("mode button did not advance");
  a_mode_refused: assert property ( // [RULE11]
    (s.mode == panel_pkg::M_NORMAL && !s.cfg_ok) |=> s.mode == panel_pkg::M_NORMAL)
    else $error("configuration entered before host load");
  a_latch_gate: assert property ( // [RULE17]
    latch_clear_o[0] |-> $past(s.rst_req[0] && !s.relay[0] && s.latched[0]))
    else $error("latch cleared while relay still in alarm");
  a_relay_hold: assert property ( // [RULE18]
    (s.delay != '0 && s.dly_cnt[0] == '0 && alarm_i[0] != s.relay[0]) |=>
      s.relay[0] == $past(s.relay[0]))
    else $error("relay moved before its delay");
  a_cfg_legal_unit: assert property ( // [RULE13]
    s.in_cfg[0].unit != 2'h3 && s.in_cfg[1].unit != 2'h3)
    else $error("illegal temperature unit stored");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // a reset request always waits, even if the relay is already clear
  a_reset_request_one: assert property ( // [RULE10]
    (press[0] || sw_rst[0]) |=> s.rst_req[0])
    else $error("relay 1 reset request not recorded");
  a_reset_request_two: assert property ( // [RULE10]
    (press[1] || sw_rst[1]) |=> s.rst_req[1])
    else $error("relay 2 reset request not recorded");
  a_capture_config: assert property ( // [RULE9]
    capture_o |-> $past(s.mode != panel_pkg::M_NORMAL))
    else $error("capture outside configuration");
  a_relay1_param_two: assert property ( // [RULE7]
    (s.mode == panel_pkg::M_R1P2) |=> lamps_o.alarm[0] == $past(s.blink))
    else $error("relay 1 lamp not flashing for parameter 2");
  a_relay2_param_two: assert property ( // [RULE7]
    (s.mode == panel_pkg::M_R2P2) |=> lamps_o.alarm[1] == $past(s.blink))
    else $error("relay 2 lamp not flashing for parameter 2");
  a_status_config: assert property ( // [RULE6]
    (s.mode != panel_pkg::M_NORMAL) |=> lamps_o.status == $past(s.sblink_cnt != '0))
    else $error("status lamp not showing capture blink");
  // stored settings never leave their legal encodings
  a_cfg_legal_func: assert property ( // [RULE15] [RULE16]
    s.in_cfg[0].func <= panel_pkg::FUNC_ROC && s.in_cfg[1].func <= panel_pkg::FUNC_ROC
      && s.in_cfg[0].wiring <= panel_pkg::WIRE_4 && s.in_cfg[1].wiring <= panel_pkg::WIRE_4)
    else $error("illegal alarm function or wiring stored");
  a_delay_clamped: assert property ( // [RULE18]
    s.delay <= panel_pkg::DLY_MAX)
    else $error("relay delay beyond four seconds");

  c_enter_config: cover property (s.mode == panel_pkg::M_NORMAL ##1 s.mode == panel_pkg::M_R1P1);
  c_capture:      cover property (capture_o);
  c_latch_clear:  cover property (latch_clear_o != 2'h0);
  c_irq:          cover property (irq_o);
  c_latch_held:   cover property (s.latched != 2'h0);

endmodule : alarm_front_panel_control

//--- tb/panel_operator.sv
`timescale 1ns/1ps
// operator at the panel: holds a button past debounce, then lets go as long
module panel_operator #(
  parameter int HOLD = 8
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic [3:0]     req_i,
  output panel_pkg::buttons_t buttons_o,
  output logic                busy_o
);
  logic [7:0] cnt;
  assign busy_o = cnt != 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt       <= 8'h00;
      buttons_o <= '0;
    end else if (!busy_o && req_i != 4'h0) begin
      cnt       <= 8'(2 * HOLD);
      buttons_o <= panel_pkg::buttons_t'(req_i);
    end else if (busy_o) begin
      cnt <= cnt - 8'h01;
      // released just as long, so the next press debounces afresh
      if (cnt == 8'(HOLD)) buttons_o <= '0;
    end
  end
endmodule : panel_operator

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int BH = 8;
  logic clk_i, rst_i, cyc, stb, we, ack, busy, cap, baud, irq;
  logic stat_q = 1'b0;
  logic [7:0]  adr;
  logic [3:0]  sel, req, lamps;
  logic [31:0] dat, dat_o, r;
  logic [1:0]  alarm, brk, relay, lclr, cap_sel;
  logic        dbusy, dfail;
  panel_pkg::buttons_t      buttons;
  panel_pkg::in_cfg_t [1:0] in_cfg;
  int error_cnt, cmp_count;
  // accumulators start here so that only the edge process writes them
  int cap_n = 0, clr_n = 0, baud_n = 0, stat_rise = 0;

  alarm_front_panel_control #(.DEBOUNCE_CYCLES(4), .BLINK_HALF_CYCLES(BH),
    .STEP_CYCLES(10), .BAUD_CYCLES(5)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .buttons_i(buttons), .alarm_i(alarm), .sensor_break_i(brk), .diag_busy_i(dbusy),
    .diag_fail_i(dfail), .lamps_o(lamps), .relay_o(relay), .latch_clear_o(lclr),
    .capture_o(cap), .capture_sel_o(cap_sel), .in_cfg_o(in_cfg), .baud_tick_o(baud),
    .irq_o(irq));
  panel_operator #(.HOLD(7)) op (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .buttons_o(buttons), .busy_o(busy));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // nonblocking so the scenarios always read the value before this edge
  always @(posedge clk_i) begin
    cap_n     <= cap_n + int'(cap);
    clr_n     <= clr_n + int'(lclr != 2'h0);
    baud_n    <= baud_n + int'(baud);
    stat_rise <= stat_rise + int'(lamps[2] && !stat_q);
    stat_q    <= lamps[2];
  end

  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(r, exp);
  endtask : rd_chk

  task automatic press(input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= b;
    @(posedge clk_i);
    req <= 4'h0;
    tick(1);
    while (busy === 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    tick(2);
  endtask : press

  // a flashing lamp inverts every half period of the shared blink
  task automatic blinks(input int b);
    logic v;
    v = lamps[b];
    tick(BH);
    chk(lamps[b], !v);
    tick(BH);
    chk(lamps[b], v);
  endtask : blinks

  task automatic t_reset();
    rd_chk(panel_pkg::ADR_CTRL, 32'h0);
    rd_chk(panel_pkg::ADR_INCFG, 32'h0);
    rd_chk(panel_pkg::ADR_DELAY, 32'h0);
    rd_chk(panel_pkg::ADR_STATUS, 32'h0);
    rd_chk(panel_pkg::ADR_IRQ_MASK, 32'h0);
    rd_chk(8'h1C, 32'h0);
    chk(lamps, 4'h8);
  endtask : t_reset

  task automatic t_diag();
    dbusy <= 1'b1;
    tick(3);
    blinks(3);
    dbusy <= 1'b0;
    dfail <= 1'b1;
    tick(3);
    blinks(3);
    dfail <= 1'b0;
    tick(3);
    chk(lamps[3], 1'b1);
  endtask : t_diag

  task automatic t_irq();
    brk <= 2'h2;
    tick(4);
    rd_chk(panel_pkg::ADR_STATUS, 32'h400);
    blinks(2);
    rd_chk(panel_pkg::ADR_IRQ_STAT, 32'h8);
    chk(irq, 1'b0);
    wr(panel_pkg::ADR_IRQ_MASK, 32'h8);
    tick(2);
    chk(irq, 1'b1);
    brk <= 2'h0;
    wr(panel_pkg::ADR_IRQ_STAT, 32'h8);
    tick(2);
    chk(irq, 1'b0);
  endtask : t_irq

  task automatic t_alarm();
    alarm <= 2'h1;
    tick(4);
    chk(relay, 2'h1);
    chk(lamps, 4'h9);
    rd_chk(panel_pkg::ADR_IRQ_STAT, 32'h2);
    alarm <= 2'h0;
    tick(4);
    chk(lamps, 4'h8);
  endtask : t_alarm

  // two 200 ms steps at the shortened step of 10 cycles: 13 to 22 cycles
  task automatic t_delay();
    wr(panel_pkg::ADR_DELAY, 32'h19);
    rd_chk(panel_pkg::ADR_DELAY, 32'h14);
    wr(panel_pkg::ADR_DELAY, 32'h2);
    alarm <= 2'h2;
    tick(8);
    chk(relay, 2'h0);
    tick(22);
    chk(relay, 2'h2);
    alarm <= 2'h0;
    tick(8);
    chk(relay, 2'h2);
    tick(22);
    chk(relay, 2'h0);
    wr(panel_pkg::ADR_DELAY, 32'h0);
  endtask : t_delay

  task automatic t_field();
    int s;
    int c;
    c = cap_n;
    press(4'h4);
    press(4'h8);
    rd_chk(panel_pkg::ADR_STATUS, 32'h0);
    chk(cap_n, c);
    wr(panel_pkg::ADR_CTRL, 32'h1);
    press(4'h8);
    rd_chk(panel_pkg::ADR_STATUS, 32'h1);
    chk(lamps[3], 1'b0);
    chk(lamps[1:0], 2'h1);
    tick(BH);
    chk(lamps[1:0], 2'h1);
    s = stat_rise;
    press(4'h4);
    tick(12);
    chk(cap_n, c + 1);
    chk(cap_sel, 2'h0);
    chk(stat_rise, s + 1);
    press(4'h8);
    rd_chk(panel_pkg::ADR_STATUS, 32'h2);
    blinks(0);
    press(4'h4);
    chk(cap_sel, 2'h1);
    press(4'h8);
    chk(lamps[1:0], 2'h2);
    press(4'h4);
    chk(cap_sel, 2'h2);
    press(4'h8);
    rd_chk(panel_pkg::ADR_STATUS, 32'h4);
    blinks(1);
    press(4'h8);
    rd_chk(panel_pkg::ADR_STATUS, 32'h0);
  endtask : t_field

  task automatic t_latch();
    int c;
    c = clr_n;
    wr(panel_pkg::ADR_CTRL, 32'h3);
    alarm <= 2'h1;
    tick(4);
    press(4'h1);
    chk(clr_n, c);
    chk(relay, 2'h1);
    alarm <= 2'h0;
    tick(6);
    chk(clr_n, c + 1);
    chk(relay, 2'h0);
    alarm <= 2'h1;
    tick(4);
    alarm <= 2'h0;
    tick(6);
    chk(relay, 2'h1);
    wr(panel_pkg::ADR_LATCH_RST, 32'h1);
    tick(4);
    chk(relay, 2'h0);
    chk(clr_n, c + 2);
    wr(panel_pkg::ADR_CTRL, 32'h5);
    alarm <= 2'h2;
    tick(4);
    alarm <= 2'h0;
    tick(6);
    chk(relay, 2'h2);
    press(4'h2);
    chk(relay, 2'h0);
    chk(clr_n, c + 3);
  endtask : t_latch

  task automatic t_cfg();
    wr(panel_pkg::ADR_INCFG, 32'h1AE);
    rd_chk(panel_pkg::ADR_INCFG, 32'h1AE);
    chk(in_cfg, 16'h01AE);
    wr(panel_pkg::ADR_INCFG, 32'h3003);
    chk(in_cfg, 16'h01AE);
    bus(1'b1, panel_pkg::ADR_INCFG, 32'h55, 4'h2);
    rd_chk(panel_pkg::ADR_INCFG, 32'hAE);
  endtask : t_cfg

  task automatic t_baud();
    int b;
    b = baud_n;
    tick(50);
    chk(baud_n - b, 10);
  endtask : t_baud

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, dat, req, alarm, brk, dbusy, dfail} = '0;
    {error_cnt, cmp_count} = '0;
    tick(10);
    rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_diag();
    t_irq();
    t_alarm();
    t_delay();
    t_field();
    t_latch();
    t_cfg();
    t_baud();
    conclude();
  end

  initial begin
    tick(20000);
    error_cnt++;
    conclude();
  end
endmodule : tb
